// ==== design/cslm_port.sv ====
// management port into the configuration space, shared with link configuration requests
// assumes link requests and application requests come from logic on the same clock
`timescale 1ns/10ps
// Functional notes
// - port exists mainly for writing header log entries; other access is debug.
// - everything runs on the one application-side clock, rated to 250 mhz.
// - fifteen-bit byte address; the two low bits are ignored.
// - reads return and writes take full 32-bit words, no byte enables.
// - port and link see identical registers with identical access attributes.
// - link configuration request wins when it collides with a port write.
// - a port write waits until no link request is pending.
// - a port read likewise waits until no link request is pending.
// - one acknowledge marks write done or read data valid.
// - only read and write operations, each started by its enable.
// - port writes change writable bits only, read-only bits stay.
module cslm_port #(
  parameter int MEM_AW = 13,
  parameter logic [31:0] ID_VALUE = cslm_pkg::ID_DEFAULT
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [cslm_pkg::ADDR_W-1:0] mgmt_addr,
  input wire logic mgmt_rden,
  input wire logic mgmt_wren,
  input wire logic [cslm_pkg::DATA_W-1:0] mgmt_din,
  output logic [cslm_pkg::DATA_W-1:0] mgmt_dout,
  output logic mgmt_ack,
  input wire logic link_cfg_req,
  input wire logic link_cfg_wr,
  input wire logic link_cfg_pending,
  input wire logic [cslm_pkg::ADDR_W-1:0] link_cfg_addr,
  input wire logic [cslm_pkg::DATA_W-1:0] link_cfg_wdata,
  output logic [cslm_pkg::DATA_W-1:0] link_cfg_rdata,
  output logic link_cfg_ack
);
  // request sequencing states: idle, held behind the link, waiting on the store
  typedef enum logic [1:0] {
    CSLM_IDLE,
    CSLM_HOLD,
    CSLM_BUSY
  } cslm_state_t;

  // elaboration guard: store cannot be wider than the word address
  if (MEM_AW < 1 || MEM_AW > cslm_pkg::IDX_W) begin : g_chk
    $error("cslm_port: MEM_AW out of range");
  end
  if (cslm_pkg::CLK_MHZ > cslm_pkg::MAX_CLK_MHZ) begin : g_clk
    $error("cslm_port: clock above rated rate");
  end
  // the port moves whole 32-bit words only
  if (cslm_pkg::DATA_W != 32) begin : g_dw
    $error("cslm_port: data width must be 32");
  end
  // the word index needs at least one bit above the byte offset
  if (cslm_pkg::ADDR_W <= cslm_pkg::WORD_LSB) begin : g_aw
    $error("cslm_port: address narrower than the byte offset");
  end
  // the tag pipeline is one stage deep, so the store must answer in one cycle
  if (cslm_pkg::MEM_LATENCY != 1) begin : g_lat
    $error("cslm_port: store read latency must be one cycle");
  end

  // read-only word decode, used by the mask and by the constant read value
  function automatic logic cslm_is_ro(input logic [cslm_pkg::IDX_W-1:0] idx);
    cslm_is_ro = (idx == cslm_pkg::RO_IDX);
  endfunction

  // one attribute table for both paths
  function automatic logic [cslm_pkg::DATA_W-1:0] cslm_wmask(input logic [cslm_pkg::IDX_W-1:0] idx);
    if (cslm_is_ro(idx)) begin
      cslm_wmask = cslm_pkg::NONE_WRITABLE;
    end else begin
      cslm_wmask = cslm_pkg::ALL_WRITABLE;
    end
  endfunction

  // drop the byte-offset bits to form a word index
  function automatic logic [cslm_pkg::IDX_W-1:0] cslm_word(input logic [cslm_pkg::ADDR_W-1:0] a);
    cslm_word = a[cslm_pkg::ADDR_W-1:cslm_pkg::WORD_LSB];
  endfunction

  cslm_state_t state_q;
  cslm_state_t state_d;

  // held port request
  logic [cslm_pkg::IDX_W-1:0] hold_idx_q;
  logic [cslm_pkg::DATA_W-1:0] hold_data_q;
  logic hold_wr_q;

  // one-stage tags following the store's read latency
  logic link_rd_s1_q;
  logic port_s1_q;

  // answer registers, one set per requester
  logic [cslm_pkg::DATA_W-1:0] mgmt_dout_q;
  logic mgmt_ack_q;
  logic [cslm_pkg::DATA_W-1:0] link_rdata_q;
  logic link_ack_q;

  // decode of incoming requests
  wire logic port_req;
  wire logic link_busy;
  wire logic port_go;
  wire logic link_go;
  wire logic [cslm_pkg::IDX_W-1:0] link_idx;
  wire logic [cslm_pkg::IDX_W-1:0] sel_idx;
  wire logic [cslm_pkg::DATA_W-1:0] sel_data;
  wire logic sel_we;
  wire logic [cslm_pkg::DATA_W-1:0] sel_mask;
  wire logic [cslm_pkg::DATA_W-1:0] sel_ro;
  wire logic [cslm_pkg::DATA_W-1:0] mem_rdata;

  // state decode and next values of the registers below
  wire logic st_idle;
  wire logic st_hold;
  wire logic port_wr_req;
  wire logic port_take;
  wire logic [cslm_pkg::IDX_W-1:0] hold_idx_d;
  wire logic [cslm_pkg::DATA_W-1:0] hold_data_d;
  wire logic hold_wr_d;
  wire logic link_rd_s1_d;
  wire logic link_wr_done;
  wire logic mgmt_ack_d;
  wire logic dout_load;
  wire logic [cslm_pkg::DATA_W-1:0] mgmt_dout_d;
  wire logic link_ack_d;
  wire logic [cslm_pkg::DATA_W-1:0] link_rdata_d;

  // a request is one of the two enables; write wins if both pulse
  assign port_req = mgmt_rden | mgmt_wren;
  // any link request in flight or queued blocks the port
  // a steady stream of link requests can starve the port; the link is never delayed
  assign link_busy = link_cfg_req | link_cfg_pending;
  // the link is served the cycle it asks
  assign link_go = link_cfg_req;
  // held port access issues only when the link is quiet
  assign port_go = st_hold & ~link_busy;
  assign link_idx = cslm_word(link_cfg_addr);

  // store port selection, link first
  assign sel_idx = link_go ? link_idx : hold_idx_q;
  assign sel_data = link_go ? link_cfg_wdata : hold_data_q;
  assign sel_we = link_go ? link_cfg_wr : (port_go & hold_wr_q);
  // read-only bits masked off on writes from either path
  assign sel_mask = cslm_wmask(sel_idx);
  assign sel_ro = cslm_is_ro(sel_idx) ? ID_VALUE : cslm_pkg::DATA_RST;

  // state decode, shared by sequencing and request capture
  assign st_idle = (state_q == CSLM_IDLE);
  assign st_hold = (state_q == CSLM_HOLD);

  // write wins when both enables pulse together
  assign port_wr_req = mgmt_wren;

  // only an idle port takes a request; enables while busy are dropped
  assign port_take = st_idle & port_req;
  assign hold_idx_d = port_take ? cslm_word(mgmt_addr) : hold_idx_q;
  assign hold_data_d = port_take ? mgmt_din : hold_data_q; // full word, no lanes
  assign hold_wr_d = port_take ? port_wr_req : hold_wr_q;

  // link tags: a read answers after the store's latency,
  // a write needs no store answer and acknowledges one cycle after issue
  assign link_rd_s1_d = link_go & ~link_cfg_wr;
  assign link_wr_done = link_go & link_cfg_wr;

  // ack marks write done or read data valid
  assign mgmt_ack_d = port_s1_q;
  // read data hold between reads, so a write leaves the last read value standing
  assign dout_load = port_s1_q & ~hold_wr_q;
  assign mgmt_dout_d = dout_load ? mem_rdata : mgmt_dout_q; // any word is readable
  assign link_ack_d = link_rd_s1_q | link_wr_done;
  assign link_rdata_d = link_rd_s1_q ? mem_rdata : link_rdata_q;

  // request sequencing
  always_comb begin
    state_d = state_q;
    case (state_q)
      CSLM_IDLE: begin
        if (port_req) begin
          state_d = CSLM_HOLD;
        end
      end
      CSLM_HOLD: begin
        if (port_go) begin
          state_d = CSLM_BUSY;
        end
      end
      CSLM_BUSY: begin
        if (port_s1_q) begin
          state_d = CSLM_IDLE;
        end
      end
      default: begin
        state_d = CSLM_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_q <= CSLM_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // capture request once; enables outside idle are ignored
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      hold_idx_q <= cslm_word(cslm_pkg::ADDR_RST);
      hold_data_q <= cslm_pkg::DATA_RST;
      hold_wr_q <= 1'b0;
    end else begin
      hold_idx_q <= hold_idx_d;
      hold_data_q <= hold_data_d;
      hold_wr_q <= hold_wr_d;
    end
  end

  // port tag follows the store's one-cycle read latency
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      port_s1_q <= 1'b0;
    end else begin
      port_s1_q <= port_go;
    end
  end

  // link read tag, so captured data goes back to the link
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      link_rd_s1_q <= 1'b0;
    end else begin
      link_rd_s1_q <= link_rd_s1_d;
    end
  end

  // ack for write completion or read data valid
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      mgmt_ack_q <= 1'b0;
    end else begin
      mgmt_ack_q <= mgmt_ack_d;
    end
  end

  // read data loaded at the same edge as its ack
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      mgmt_dout_q <= cslm_pkg::DATA_RST;
    end else begin
      mgmt_dout_q <= mgmt_dout_d;
    end
  end

  // link side answers; link writes acknowledge one cycle after issue
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      link_ack_q <= 1'b0;
    end else begin
      link_ack_q <= link_ack_d;
    end
  end

  // link read data, held until the next link read
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      link_rdata_q <= cslm_pkg::DATA_RST;
    end else begin
      link_rdata_q <= link_rdata_d;
    end
  end

  // one store serves both paths, so both see the same bits
  // a write also loads the store's read register with the old word;
  // the link read tag stays low and the port data load is gated off for writes, so nobody takes that value
  cslm_cfg_mem #(
    .AW(MEM_AW),
    .DW(cslm_pkg::DATA_W)
  ) u_mem (
    .clock(clock),
    .sys_rst(sys_rst),
    .we(sel_we),
    .addr(sel_idx[MEM_AW-1:0]),
    .wdata(sel_data),
    .wmask(sel_mask),
    .ro_value(sel_ro),
    .rdata_q(mem_rdata)
  );

  // header log words are ordinary writable words of the store
  assign mgmt_dout = mgmt_dout_q;
  assign mgmt_ack = mgmt_ack_q;
  assign link_cfg_rdata = link_rdata_q;
  assign link_cfg_ack = link_ack_q;
endmodule

// ==== design/cslm_pkg.sv ====
// constants shared by the configuration-space management port and its store
// assumes one 100 mhz application-side clock and a synchronous active-high reset
package cslm_pkg;
  // port geometry
  localparam int ADDR_W = 15;
  localparam int DATA_W = 32;
  localparam int WORD_LSB = 2;
  localparam int IDX_W = ADDR_W - WORD_LSB;
  // clocking: the port is rated up to this rate
  localparam int CLK_MHZ = 100;
  localparam int MAX_CLK_MHZ = 250;
  // access attributes: word index of the read-only identity word
  localparam logic [IDX_W-1:0] RO_IDX = 13'h0000;
  localparam logic [DATA_W-1:0] ALL_WRITABLE = 32'hffffffff;
  localparam logic [DATA_W-1:0] NONE_WRITABLE = 32'h00000000;
  // identity word default, value is arbitrary
  localparam logic [DATA_W-1:0] ID_DEFAULT = 32'h5a5a0001;
  // reset values
  localparam logic [DATA_W-1:0] DATA_RST = 32'h00000000;
  localparam logic [ADDR_W-1:0] ADDR_RST = 15'h0000;
  // pipeline: cycles from issue to captured read data
  localparam int MEM_LATENCY = 1;
endpackage

// ==== design/cslm_cfg_mem.sv ====
// configuration word store with a per-bit writable mask and registered read data
// assumes the caller supplies mask and read-only value for the addressed word
`timescale 1ns/10ps
module cslm_cfg_mem #(
  parameter int AW = 13,
  parameter int DW = 32
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  input wire logic [DW-1:0] wmask,
  input wire logic [DW-1:0] ro_value,
  output logic [DW-1:0] rdata_q
);
  logic [DW-1:0] mem [0:(1<<AW)-1];
  logic [DW-1:0] merged;
  logic [DW-1:0] stored;

  // the store needs at least one address bit and one data bit
  if (AW < 1 || DW < 1) begin : g_chk
    $error("cslm_cfg_mem: bad geometry");
  end

  // only writable bits take new data, the rest keep their value
  assign stored = mem[addr];
  assign merged = (stored & ~wmask) | (wdata & wmask);

  // array write, no reset since the array is plain storage
  always_ff @(posedge clock) begin
    if (we) begin
      mem[addr] <= merged;
    end
  end

  // read-only bits come from the constant, so unwritten words read defined there
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= (stored & wmask) | (ro_value & ~wmask);
    end
  end
endmodule

// ==== test/cslm_port_sva.sv ====
// assertions on the management port and the link path
// assumes one clock and a synchronous active-high reset
`timescale 1ns/10ps
module cslm_port_sva (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic mgmt_rden,
  input wire logic mgmt_wren,
  input wire logic [31:0] mgmt_dout,
  input wire logic mgmt_ack,
  input wire logic link_cfg_req,
  input wire logic link_cfg_wr,
  input wire logic link_cfg_pending,
  input wire logic link_cfg_ack
);
  logic busy_q;
  logic busy_d;
  wire take = (mgmt_rden | mgmt_wren) & (~busy_q | mgmt_ack);
  wire link_busy = link_cfg_req | link_cfg_pending;
  // outstanding port request, cleared by its acknowledge
  assign busy_d = take | (busy_q & ~mgmt_ack);
  always_ff @(posedge clock) begin
    busy_q <= sys_rst ? 1'b0 : busy_d;
  end
  default clocking cb @(posedge clock); endclocking
  sequence s_quiet_req;
    take ##1 (!link_busy) [*3];
  endsequence
  sequence s_held_req;
    take ##1 link_busy;
  endsequence
  a_ack_one_cycle: assert property (disable iff (sys_rst) mgmt_ack |=> !mgmt_ack)
    else $error("port ack longer than one cycle");
  a_ack_has_req: assert property (disable iff (sys_rst) mgmt_ack |-> busy_q)
    else $error("port ack without a request");
  a_quiet_latency: assert property (disable iff (sys_rst) s_quiet_req |-> mgmt_ack)
    else $error("port ack late with link quiet");
  a_link_holds_port: assert property (disable iff (sys_rst) s_held_req |-> ##1 !mgmt_ack ##1 !mgmt_ack)
    else $error("port served while link busy");
  a_ack_bounded: assert property (disable iff (sys_rst) take |-> ##[3:40] mgmt_ack)
    else $error("port request never acknowledged");
  a_dout_held: assert property (disable iff (sys_rst) !$stable(mgmt_dout) |-> mgmt_ack)
    else $error("read data moved outside ack");
  a_link_wr_first: assert property (disable iff (sys_rst) link_cfg_req && link_cfg_wr |=> link_cfg_ack)
    else $error("link write not served at once");
  a_link_rd_first: assert property (disable iff (sys_rst) link_cfg_req && !link_cfg_wr |-> ##2 link_cfg_ack)
    else $error("link read not served at once");
  a_reset_clear: assert property (sys_rst |=> !mgmt_ack && !link_cfg_ack && mgmt_dout == 32'h0)
    else $error("outputs not cleared by reset");
endmodule
bind cslm_port cslm_port_sva cslm_port_sva_inst (.clock(clock), .sys_rst(sys_rst), .mgmt_rden(mgmt_rden),
  .mgmt_wren(mgmt_wren), .mgmt_dout(mgmt_dout), .mgmt_ack(mgmt_ack), .link_cfg_req(link_cfg_req),
  .link_cfg_wr(link_cfg_wr), .link_cfg_pending(link_cfg_pending), .link_cfg_ack(link_cfg_ack));

// ==== test/cslm_app_model.sv ====
// application-side requester for the management port
// assumes requests are launched at the falling edge of clock
`timescale 1ns/10ps
module cslm_app_model (
  input wire logic clock,
  input wire logic mgmt_ack,
  input wire logic [31:0] mgmt_dout,
  output logic [14:0] mgmt_addr,
  output logic mgmt_rden,
  output logic mgmt_wren,
  output logic [31:0] mgmt_din
);
  initial begin
    mgmt_addr = 15'h0000;
    mgmt_rden = 1'b0;
    mgmt_wren = 1'b0;
    mgmt_din = 32'h0;
  end
  // one pulse, lines held until ack
  task automatic xfer(input logic w, input logic [14:0] a, input logic [31:0] d,
                      output logic [31:0] q, output int n);
    n = 0;
    q = 32'h0;
    @(negedge clock);
    mgmt_addr <= a;
    mgmt_din <= d;
    mgmt_rden <= !w;
    mgmt_wren <= w;
    @(negedge clock);
    mgmt_rden <= 1'b0;
    mgmt_wren <= 1'b0;
    // n counts cycles from the request; bounded so a lost ack cannot hang
    for (int i = 2; i < 40 && n == 0; i++) begin
      @(negedge clock);
      if (mgmt_ack === 1'b1) begin
        n = i;
        q = mgmt_dout;
      end
    end
    // inverse on release so a stale value never looks held
    mgmt_addr <= ~a;
    mgmt_din <= ~d;
  endtask
endmodule

// ==== test/tb_top.sv ====
// self-checking bench for the management port
// assumes the port and its bound checker are compiled alongside
`timescale 1ns/10ps
module tb_top;
  localparam logic [31:0] ID = 32'h3c3c0007; // arbitrary identity value
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic link_cfg_req = 1'b0;
  logic link_cfg_wr = 1'b0;
  logic link_cfg_pending = 1'b0;
  logic [14:0] link_cfg_addr = 15'h0;
  logic [31:0] link_cfg_wdata = 32'h0;
  wire [14:0] mgmt_addr;
  wire mgmt_rden;
  wire mgmt_wren;
  wire mgmt_ack;
  wire link_cfg_ack;
  wire [31:0] mgmt_din;
  wire [31:0] mgmt_dout;
  wire [31:0] link_cfg_rdata;
  int error_cnt = 0;
  int n_tests = 0;
  int n;
  logic [31:0] q;
  // 100 mhz clock
  always #5 clock = ~clock;
  cslm_port #(.MEM_AW(6), .ID_VALUE(ID)) cslm_port_inst (.clock(clock), .sys_rst(sys_rst),
    .mgmt_addr(mgmt_addr), .mgmt_rden(mgmt_rden), .mgmt_wren(mgmt_wren), .mgmt_din(mgmt_din),
    .mgmt_dout(mgmt_dout), .mgmt_ack(mgmt_ack), .link_cfg_req(link_cfg_req), .link_cfg_wr(link_cfg_wr),
    .link_cfg_pending(link_cfg_pending), .link_cfg_addr(link_cfg_addr), .link_cfg_wdata(link_cfg_wdata),
    .link_cfg_rdata(link_cfg_rdata), .link_cfg_ack(link_cfg_ack));
  cslm_app_model cslm_app_model_inst (.clock(clock), .mgmt_ack(mgmt_ack), .mgmt_dout(mgmt_dout),
    .mgmt_addr(mgmt_addr), .mgmt_rden(mgmt_rden), .mgmt_wren(mgmt_wren), .mgmt_din(mgmt_din));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // one port transfer; a missing ack ends the run
  task automatic go(input logic w, input logic [14:0] a, input logic [31:0] d);
    cslm_app_model_inst.xfer(w, a, d, q, n);
    if (n == 0) begin
      error_cnt++;
      give_verdict();
    end
  endtask
  task automatic t_reset();
    sys_rst = 1'b1;
    repeat (3) @(negedge clock);
    sys_rst = 1'b0;
    chk({31'h0, mgmt_ack}, 32'h0);
    chk(mgmt_dout, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_word();
    go(1'b1, 15'h0013, 32'ha5c30f96);
    chk(n, 3);
    go(1'b0, 15'h0010, 32'h0);
    chk(q, 32'ha5c30f96);
    chk(n, 3);
    $display("test word done");
  endtask
  task automatic t_ro();
    go(1'b1, 15'h0002, ~ID);
    chk(mgmt_dout, 32'ha5c30f96);
    go(1'b0, 15'h0000, 32'h0);
    chk(q, ID);
    $display("test read-only done");
  endtask
  // link write and pending collide with a port write
  task automatic t_prio();
    fork
      go(1'b1, 15'h0020, 32'h1234abcd);
      begin
        repeat (2) @(negedge clock);
        link_cfg_req = 1'b1;
        link_cfg_wr = 1'b1;
        link_cfg_addr = 15'h0024;
        link_cfg_wdata = 32'h0badf00d;
        link_cfg_pending = 1'b1;
        @(negedge clock);
        link_cfg_req = 1'b0;
        chk({31'h0, link_cfg_ack}, 32'h1);
        @(negedge clock);
        link_cfg_pending = 1'b0;
      end
    join
    chk(n, 5);
    go(1'b0, 15'h0024, 32'h0);
    chk(q, 32'h0badf00d);
    @(negedge clock);
    link_cfg_req = 1'b1;
    link_cfg_wr = 1'b0;
    link_cfg_addr = 15'h0020;
    @(negedge clock);
    link_cfg_req = 1'b0;
    @(negedge clock);
    chk(link_cfg_rdata, 32'h1234abcd);
    chk({31'h0, link_cfg_ack}, 32'h1);
    $display("test priority done");
  endtask
  initial begin
    t_reset();
    t_word();
    t_ro();
    t_prio();
    t_reset();
    give_verdict();
  end
endmodule
